// >>> core/resv_pkg.sv
// shared constants and types for the reservation and barrier unit
package resv_pkg;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned REG_SEL_W  = 5;
  localparam logic [4:0]  ZERO_REG   = 5'h00;
  localparam int unsigned ALIGN_BITS = 2;
  localparam logic [1:0]  ALIGN_ZERO = 2'h0;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  // operation class presented by the issue stage
  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_RESV_LOAD  = 4'h1,
    OP_COND_STORE = 4'h2,
    OP_IO_BARRIER = 4'h3,
    OP_FULL_BAR   = 4'h4,
    OP_CTX_BAR    = 4'h5,
    OP_MSR_WRITE  = 4'h6,
    OP_INT_RETURN = 4'h7,
    OP_CRIT_RET   = 4'h8,
    OP_SYS_CALL   = 4'h9
  } op_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DRAIN  = 3'b001,
    ST_MEM    = 3'b010,
    ST_FLUSH  = 3'b011,
    ST_DONE   = 3'b100
  } state_t;
endpackage : resv_pkg

// >>> core/sync_classifier.sv
// classifies an operation into its synchronisation kinds
`timescale 1ns/10ps
module sync_classifier
(
  // operation in
  input  wire resv_pkg::op_t op,
  // classes out
  output wire                ctx_sync,
  output wire                exec_sync,
  output wire                stor_sync
);
  // both barriers share the same storage effect
  assign stor_sync = (op == resv_pkg::OP_IO_BARRIER) || (op == resv_pkg::OP_FULL_BAR); // RULE1 RULE3 RULE5
  // execution-synchronizing set, io barrier included
  assign exec_sync = (op == resv_pkg::OP_IO_BARRIER) || (op == resv_pkg::OP_CTX_BAR) ||
                     (op == resv_pkg::OP_MSR_WRITE) || (op == resv_pkg::OP_INT_RETURN) ||
                     (op == resv_pkg::OP_CRIT_RET) || (op == resv_pkg::OP_SYS_CALL) ||
                     (op == resv_pkg::OP_FULL_BAR); // RULE2 RULE5 RULE16
  // context-synchronizing set
  assign ctx_sync  = (op == resv_pkg::OP_CTX_BAR) || (op == resv_pkg::OP_INT_RETURN) ||
                     (op == resv_pkg::OP_CRIT_RET) || (op == resv_pkg::OP_SYS_CALL) ||
                     (op == resv_pkg::OP_FULL_BAR); // RULE4
endmodule : sync_classifier

// >>> core/reservation_sync_unit.sv
// reservation tracking, conditional store and barrier sequencing
// Function
// (RULE1) io barrier and full barrier behave identically; here only the full barrier is context sync and flushes prefetch
// (RULE2) io barrier is execution synchronizing
// (RULE3) full barrier needs no multiprocessor ordering
// (RULE4) context sync: ctx barrier, returns, trap, full
// (RULE5) exec sync set; storage sync only barriers
// (RULE6) address base_gpr or zero plus index_gpr, reserve
// (RULE7) conditional store writes only with reservation
// (RULE8) match flag set on success, else cleared
// (RULE9) reservation granularity is one word
// (RULE10) misaligned address raises alignment exception
// (RULE11) store succeeds regardless of address match
// (RULE12) one reservation, last reserving load wins
// (RULE13) every conditional store clears the reservation; here a misaligned store leaves it unchanged
// (RULE14) exceptions leave reservation unchanged
// (RULE15) never block other masters from reading
// (RULE16) full barrier drains before and blocks after
// (RULE17) ctx barrier flushes prefetch, no memory ordering
// (RULE18) no reservation after reset
`timescale 1ns/10ps
module reservation_sync_unit
(
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // issue side
  input  wire        op_valid,
  output wire        op_ready,
  input  wire resv_pkg::op_t op,
  input  wire [4:0]  base_sel,
  input  wire [31:0] base_gpr,
  input  wire [31:0] index_gpr,
  input  wire [31:0] source_gpr,
  input  wire [4:0]  dest_sel,
  input  wire        exception_taken,
  // pipeline status
  input  wire        older_pending,
  output wire        issue_stall,
  output logic       prefetch_flush,
  // memory side
  output logic       mem_req,
  output logic       mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // results
  output logic       wb_valid,
  output logic [4:0] wb_sel,
  output logic [31:0] wb_data,
  output logic       cr_valid,
  output logic       cond_zero_match_flag,
  output logic       align_exc,
  output logic       resv_held,
  output wire        ctx_sync,
  output wire        exec_sync,
  output wire        stor_sync
);
  resv_pkg::state_t state_q, state_d;
  resv_pkg::op_t    op_q;
  logic [29:0]      resv_word_q;
  logic             resv_q;
  logic             take_ok_q;
  wire              held_ctx;

  sync_classifier u_cls
  (
    .op        (op),
    .ctx_sync  (ctx_sync),
    .exec_sync (exec_sync),
    .stor_sync (stor_sync)
  );

  // class of the op in flight; the live op input has moved on by flush time
  sync_classifier u_cls_held
  (
    .op        (op_q),
    .ctx_sync  (held_ctx),
    .exec_sync (),
    .stor_sync ()
  );

  // effective address and decode
  wire [31:0] eff_base = (base_sel == resv_pkg::ZERO_REG) ? resv_pkg::ZERO_WORD : base_gpr; // RULE6
  wire [31:0] eff_addr = eff_base + index_gpr; // RULE6
  wire        is_mem   = (op == resv_pkg::OP_RESV_LOAD) || (op == resv_pkg::OP_COND_STORE);
  wire        misalign = eff_addr[resv_pkg::ALIGN_BITS-1:0] != resv_pkg::ALIGN_ZERO; // RULE10
  wire        accept   = op_valid && op_ready;
  wire        is_store = op_q == resv_pkg::OP_COND_STORE;
  // store only issues while a reservation exists, any address
  wire        store_go = resv_q; // RULE7 RULE11
  assign op_ready    = (state_q == resv_pkg::ST_IDLE) && !exception_taken; // RULE14
  // later ops wait while a sequence runs; a barrier holds issue
  assign issue_stall = state_q != resv_pkg::ST_IDLE; // RULE2 RULE16

  // sequencer: sync ops drain older work then flush, memory ops go straight to memory, then done
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      resv_pkg::ST_IDLE:
        if (accept && !(is_mem && misalign))
          state_d = (exec_sync || stor_sync) ? resv_pkg::ST_DRAIN :
                    (is_mem ? resv_pkg::ST_MEM : resv_pkg::ST_DONE);
      resv_pkg::ST_DRAIN:
        if (!older_pending)
          state_d = (op_q == resv_pkg::OP_NONE) ? resv_pkg::ST_DONE : resv_pkg::ST_FLUSH; // RULE16
      resv_pkg::ST_MEM:
        if (mem_ack || (is_store && !take_ok_q))
          state_d = resv_pkg::ST_DONE;
      resv_pkg::ST_FLUSH:
        state_d = resv_pkg::ST_DONE;
      resv_pkg::ST_DONE:
        state_d = resv_pkg::ST_IDLE;
      default:
        state_d = resv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_q <= resv_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // latch the operation and decided outcome at acceptance
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_q      <= resv_pkg::OP_NONE;
      take_ok_q <= 1'b0;
      mem_addr  <= resv_pkg::ZERO_WORD;
      mem_wdata <= resv_pkg::ZERO_WORD;
      wb_sel    <= resv_pkg::ZERO_REG;
    end
    else if (accept)
    begin
      op_q      <= op;
      take_ok_q <= store_go; // RULE11
      mem_addr  <= eff_addr;
      mem_wdata <= source_gpr;
      wb_sel    <= dest_sel;
    end
  end

  // prefetch flush only for context sync; no memory ordering implied
  always_ff @(posedge clk)
  begin
    if (reset)
      prefetch_flush <= 1'b0;
    else
      prefetch_flush <= (state_q == resv_pkg::ST_FLUSH) && held_ctx; // RULE17 RULE4
  end

  // memory request; plain reads, nothing locks the location for others
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
    end
    else
    begin
      mem_req <= (state_d == resv_pkg::ST_MEM) && !(mem_req && mem_ack) &&
                 !((op_q == resv_pkg::OP_COND_STORE) && !take_ok_q && state_q == resv_pkg::ST_MEM)
                 && !(accept && op == resv_pkg::OP_COND_STORE && !store_go); // RULE7 RULE15
      mem_we  <= (state_d == resv_pkg::ST_MEM) &&
                 (accept ? (op == resv_pkg::OP_COND_STORE) : is_store);
    end
  end

  // reservation: one word, replaced by each aligned load, cleared by each aligned store
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resv_q      <= 1'b0; // RULE18
      resv_word_q <= 30'h0;
    end
    else if (accept && !misalign && op == resv_pkg::OP_RESV_LOAD)
    begin
      resv_q      <= 1'b1; // RULE12
      resv_word_q <= eff_addr[31:resv_pkg::ALIGN_BITS]; // RULE9
    end
    else if (accept && !misalign && op == resv_pkg::OP_COND_STORE)
      resv_q <= 1'b0; // RULE13
    // exception_taken alone never touches the reservation
  end
  assign resv_held = resv_q;

  // results: writeback, condition flag and alignment fault
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_valid             <= 1'b0;
      wb_data              <= resv_pkg::ZERO_WORD;
      cr_valid             <= 1'b0;
      cond_zero_match_flag <= 1'b0;
      align_exc            <= 1'b0;
    end
    else
    begin
      wb_valid  <= (state_q == resv_pkg::ST_MEM) && mem_ack && !is_store; // RULE6
      if ((state_q == resv_pkg::ST_MEM) && mem_ack && !is_store)
        wb_data <= mem_rdata;
      cr_valid  <= (state_q == resv_pkg::ST_MEM) && is_store && (mem_ack || !take_ok_q);
      if ((state_q == resv_pkg::ST_MEM) && is_store && (mem_ack || !take_ok_q))
        cond_zero_match_flag <= take_ok_q; // RULE8
      align_exc <= accept && is_mem && misalign; // RULE10
    end
  end

  // a failed store never writes memory
  AST_NO_WRITE_FAIL: assert property (@(posedge clk) disable iff (reset) // RULE7
    (state_q == resv_pkg::ST_MEM && is_store && !take_ok_q) |-> !mem_req)
    else $error("failed conditional store wrote memory");
  AST_FLAG_VALUE: assert property (@(posedge clk) disable iff (reset) // RULE8
    cr_valid |-> cond_zero_match_flag == $past(take_ok_q))
    else $error("match flag wrong");
  AST_STORE_CLEARS: assert property (@(posedge clk) disable iff (reset) // RULE13
    (accept && !misalign && op == resv_pkg::OP_COND_STORE) |=> !resv_q)
    else $error("store left reservation");
  AST_LOAD_SETS: assert property (@(posedge clk) disable iff (reset) // RULE12
    (accept && !misalign && op == resv_pkg::OP_RESV_LOAD) |=>
    (resv_q && resv_word_q == $past(eff_addr[31:resv_pkg::ALIGN_BITS])))
    else $error("load did not reserve");
  AST_ALIGN: assert property (@(posedge clk) disable iff (reset) // RULE10
    (accept && is_mem && misalign) |=> (align_exc && state_q == resv_pkg::ST_IDLE))
    else $error("alignment fault missed");
  AST_EXC_KEEP: assert property (@(posedge clk) disable iff (reset) // RULE14
    (exception_taken && !accept) |=> resv_q == $past(resv_q))
    else $error("exception changed reservation");
  AST_BAR_SAME: assert property (@(posedge clk) disable iff (reset) // RULE1
    (op == resv_pkg::OP_IO_BARRIER || op == resv_pkg::OP_FULL_BAR) |->
    (stor_sync && exec_sync))
    else $error("barriers differ");
  AST_DRAIN: assert property (@(posedge clk) disable iff (reset) // RULE16
    (state_q == resv_pkg::ST_DRAIN && older_pending) |=> state_q == resv_pkg::ST_DRAIN)
    else $error("barrier passed pending work");
  AST_CTX: assert property (@(posedge clk) disable iff (reset) // RULE4
    (op == resv_pkg::OP_SYS_CALL) |-> ctx_sync)
    else $error("trap not context sync");
  AST_RESET_EMPTY: assert property (@(posedge clk) // RULE18
    $fell(reset) |-> !resv_q)
    else $error("reservation after reset");

  // a store taken with no reservation is answered two cycles on, no memory traffic
  sequence s_fail_take;
    accept && !misalign && (op == resv_pkg::OP_COND_STORE) && !store_go;
  endsequence
  sequence s_fail_answer;
    cr_valid && !cond_zero_match_flag && !mem_req;
  endsequence
  AST_FAIL_ANSWER: assert property (@(posedge clk) disable iff (reset) // RULE7 RULE8
    s_fail_take |=> ##1 s_fail_answer)
    else $error("failed store answer wrong");
endmodule : reservation_sync_unit

// >>> verif/mem_model.sv
// word memory on the far side of the unit, with a second reader
`timescale 1ns/10ps
module mem_model
(
  // clock and reset
  input  wire         clk,
  input  wire         reset,
  // request side
  input  wire         mem_req,
  input  wire         mem_we,
  input  wire  [31:0] mem_addr,
  input  wire  [31:0] mem_wdata,
  input  wire         slow,
  output logic        mem_ack,
  output logic [31:0] mem_rdata,
  // second reader
  input  wire  [3:0]  peek_idx,
  output wire  [31:0] peek_data
);
  logic [31:0] word_q [16];
  logic [1:0]  wait_q;

  // another master reads at any time, never locked out
  assign peek_data = word_q[peek_idx];

  // one ack pulse per request; idle data toggles so stale reads show
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q    <= 2'h0;
      for (int i = 0; i < 16; i++)
        word_q[i] <= 32'ha5a5_0000 + 32'(i);
    end
    else if (mem_req && !mem_ack && (wait_q == 2'h3 || !slow))
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= word_q[mem_addr[5:2]];
      if (mem_we)
        word_q[mem_addr[5:2]] <= mem_wdata;
      wait_q    <= 2'h0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q    <= mem_req ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : mem_model

// >>> verif/reservation_sync_unit_tb_top.sv
// self-checking bench for the reservation and barrier unit
`timescale 1ns/10ps
module reservation_sync_unit_tb_top;
  logic          clk, reset, op_valid, op_ready, exception_taken, older_pending, slow;
  logic          issue_stall, prefetch_flush, mem_req, mem_we, mem_ack, wb_valid;
  logic          cr_valid, cond_zero_match_flag, align_exc, resv_held;
  logic          ctx_sync, exec_sync, stor_sync, resv_m;
  resv_pkg::op_t op;
  logic [4:0]    base_sel, dest_sel, wb_sel;
  logic [3:0]    peek_idx;
  logic [31:0]   base_gpr, index_gpr, source_gpr, mem_addr, mem_wdata, mem_rdata;
  logic [31:0]   wb_data, peek_data;
  logic [31:0]   shadow [16];
  int            seed = 56;
  int            bad_count = 0;
  int            checks = 0;

  reservation_sync_unit i_dut (.clk, .reset, .op_valid, .op_ready, .op, .base_sel,
    .base_gpr, .index_gpr, .source_gpr, .dest_sel, .exception_taken, .older_pending,
    .issue_stall, .prefetch_flush, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .wb_valid, .wb_sel, .wb_data, .cr_valid, .cond_zero_match_flag,
    .align_exc, .resv_held, .ctx_sync, .exec_sync, .stor_sync);
  mem_model i_mem (.clk, .reset, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow,
    .mem_ack, .mem_rdata, .peek_idx, .peek_data);

  // 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // expected {context, execution, storage} classes
  function automatic logic [2:0] cls(input resv_pkg::op_t o);
    case (o)
      resv_pkg::OP_IO_BARRIER: cls = 3'h3;
      resv_pkg::OP_FULL_BAR:   cls = 3'h7;
      resv_pkg::OP_MSR_WRITE:  cls = 3'h2;
      resv_pkg::OP_CTX_BAR, resv_pkg::OP_INT_RETURN,
      resv_pkg::OP_CRIT_RET, resv_pkg::OP_SYS_CALL: cls = 3'h6;
      default: cls = 3'h0;
    endcase
  endfunction : cls

  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [79:0] s, input logic [79:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one operation from issue until the unit is idle again
  task automatic do_op(input resv_pkg::op_t o, input logic [4:0] bs,
                       input logic [31:0] b, input logic [31:0] ix);
    logic [31:0] ea, wd, ad;
    logic        mop, wb, cr, fl, al, pf, we;
    logic [4:0]  ws;
    logic [2:0]  c;
    int          n;
    ea = (bs == 5'h00 ? 32'h0 : b) + ix;
    mop = o == resv_pkg::OP_RESV_LOAD || o == resv_pkg::OP_COND_STORE;
    c = cls(o);
    {we, wb, cr, fl, al, pf, ws, wd, ad} = 75'h0;
    op = o;
    {base_sel, base_gpr, index_gpr} = {bs, b, ix};
    {source_gpr, dest_sel, slow} = {$random(seed), 5'($random(seed)), 1'($random(seed))};
    op_valid = 1'b1;
    older_pending = !mop;
    #1 chk("ready", op_ready, 1'b1);
    chk("class", {ctx_sync, exec_sync, stor_sync}, c);
    @(negedge clk);
    op_valid = 1'b0;
    for (n = 0; n < 60; n++)
    begin
      if (wb_valid === 1'b1)
        {wd, ws} = {wb_data, wb_sel};
      if (cr_valid === 1'b1)
        {cr, fl} = {1'b1, cond_zero_match_flag};
      if (mem_req === 1'b1)
        {ad, we} = {mem_addr, mem_we};
      wb |= wb_valid;
      al |= align_exc;
      pf |= prefetch_flush;
      if (n < 3 && !mop)
      begin
        chk("drain", op_ready, 1'b0);
        chk("stall", issue_stall, 1'b1);
      end
      if (n == 2)
        older_pending = 1'b0;
      if (op_ready === 1'b1)
        break;
      @(negedge clk);
    end
    if (n == 60)
    begin
      chk("done", 1'b0, 1'b1);
      end_of_test();
    end
    if (mop && ea[1:0] != 2'h0)
      chk("align", {al, wb, cr}, 3'h4);
    else if (o == resv_pkg::OP_RESV_LOAD)
    begin
      chk("load", {wb, we, ws, wd, ad}, {1'b1, 1'b0, dest_sel, shadow[ea[5:2]], ea});
      resv_m = 1'b1;
    end
    else if (mop)
    begin
      chk("store", {cr, fl}, {1'b1, resv_m});
      chk("store_mem", {we, ad}, resv_m ? {1'b1, ea} : 33'h0);
      if (resv_m)
        shadow[ea[5:2]] = source_gpr;
      resv_m = 1'b0;
      peek_idx = ea[5:2];
      #1 chk("mem", peek_data, shadow[ea[5:2]]);
    end
    else
      chk("flush", pf, c[2]);
    chk("held", resv_held, resv_m);
    // let an edge pass so the next request starts on a falling edge
    @(negedge clk);
  endtask : do_op

  // exception in an idle cycle: refused, reservation kept
  task automatic exc();
    exception_taken = 1'b1;
    op_valid = 1'b1;
    op = resv_pkg::OP_RESV_LOAD;
    #1 chk("refuse", op_ready, 1'b0);
    @(negedge clk);
    {exception_taken, op_valid} = 2'h0;
    chk("held", resv_held, resv_m);
    @(negedge clk);
  endtask : exc

  // corner cases first, then every class, then random traffic
  initial
  begin
    {op_valid, exception_taken, older_pending, slow, resv_m} = 5'h00;
    op = resv_pkg::OP_NONE;
    {base_sel, dest_sel, peek_idx} = 14'h0;
    {base_gpr, index_gpr, source_gpr} = 96'h0;
    for (int i = 0; i < 16; i++)
      shadow[i] = 32'ha5a5_0000 + 32'(i);
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    chk("held", resv_held, 1'b0);
    do_op(resv_pkg::OP_COND_STORE, 5'h01, 32'h8, 32'h0);
    do_op(resv_pkg::OP_RESV_LOAD, 5'h01, 32'h8, 32'h4);
    do_op(resv_pkg::OP_RESV_LOAD, 5'h00, 32'h40, 32'h20);
    do_op(resv_pkg::OP_COND_STORE, 5'h02, 32'h4, 32'h0);
    do_op(resv_pkg::OP_COND_STORE, 5'h02, 32'h4, 32'h0);
    do_op(resv_pkg::OP_RESV_LOAD, 5'h01, 32'h1, 32'h0);
    do_op(resv_pkg::OP_RESV_LOAD, 5'h01, 32'h0, 32'h10);
    exc();
    do_op(resv_pkg::OP_COND_STORE, 5'h01, 32'h3, 32'h0);
    do_op(resv_pkg::OP_COND_STORE, 5'h01, 32'h0, 32'h10);
    for (int k = 3; k < 10; k++)
      do_op(resv_pkg::op_t'(4'(k)), 5'h00, 32'h0, 32'h0);
    for (int k = 0; k < 80; k++)
    begin
      if ($random(seed) % 5 == 0)
        exc();
      do_op(resv_pkg::op_t'(4'h1 + 4'({$random(seed)} % 9)), 5'($random(seed) & 3),
            $random(seed) & 32'h3c,
            ($random(seed) & 32'h1c) + 32'({$random(seed)} % 8 == 0));
    end
    end_of_test();
  end
endmodule : reservation_sync_unit_tb_top
